// file: rtl/pms_top.sv
// Power mode controller and system clock switch with status flags
//
// Contract
// - A switch takes two old-source edges plus three to four new-source edges.
// - Primary-clock-active flag, control register bit 3, set while primary clocks device.
// - Secondary-running flag, second control register bit 6, set while secondary clocks.
// - Both flags clear while the internal RC oscillator clocks the device.
// - At most one of the two source flags is set at a time.
// - Sleep instruction is only a trigger; target mode follows the select bits.
// - Target mode uses idle and deep-sleep bits sampled at the sleep instruction.
// - Each later sleep instruction samples the bits again and enters the new mode.
// - Deep enable gives Deep Sleep, idle gives Idle, neither gives Sleep; mode codes 10/01/11.
// - Clock select field clears on every reset, back to primary source.
`timescale 1ns/100ps
module pms_top
	import pms_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic [1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic sleep_exec_i,
	input wire logic wake_i,
	input wire logic pri_tick_i,
	input wire logic sec_tick_i,
	input wire logic rc_tick_i,
	output logic [1:0] clk_src_o,
	output logic switching_o,
	output logic [1:0] pwr_mode_o,
	output logic cpu_clk_en_o,
	output logic periph_clk_en_o
);
	pms_sw_if sw ();

	pms_src_e sel_r, sel_nxt, act_r, act_nxt;
	// Target held from start, as select may be rewritten while counting
	pms_src_e tgt_r, tgt_nxt;
	pms_mode_e mode_r, mode_nxt;
	logic idle_r, idle_nxt, deep_sleep_enable_bit_r, deep_sleep_enable_bit_nxt;
	logic pri_flag_r, pri_flag_nxt, sec_flag_r, sec_flag_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic osc_wr;
	pms_src_e wr_sel;

	assign osc_wr = reg_wr_i && (reg_addr_i == PMS_OSC_CTRL_ADDR);
	assign wr_sel = pms_src_e'(reg_wdata_i[PMS_SCS_LSB +: 2]);

	always_comb begin
		sel_nxt = sel_r;
		idle_nxt = idle_r;
		deep_sleep_enable_bit_nxt = deep_sleep_enable_bit_r;
		if (osc_wr) begin
			idle_nxt = reg_wdata_i[PMS_IDLE_BIT];
			// Reserved select code is dropped so the timer never sees it
			if (wr_sel != PMS_SRC_BAD) begin
				sel_nxt = wr_sel;
			end
		end
		if (reg_wr_i && reg_addr_i == PMS_DEEP_CTRL_ADDR) begin
			deep_sleep_enable_bit_nxt = reg_wdata_i[PMS_DEEP_SLEEP_ENABLE_BIT_BIT];
		end
	end

	// Timer is restarted for any pending difference once idle
	assign sw.start = (sel_r != act_r) && !sw.busy;
	assign sw.old_src = act_r;
	assign sw.new_src = sel_r;
	assign sw.ticks = {rc_tick_i, sec_tick_i, pri_tick_i};

	pms_switch_timer u_timer (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.sw(sw)
	);

	always_comb begin
		act_nxt = act_r;
		tgt_nxt = tgt_r;
		if (sw.start) begin
			tgt_nxt = sel_r;
		end
		// Active source and flags move only on completion
		if (sw.done) begin
			act_nxt = tgt_r;
		end
		pri_flag_nxt = (act_nxt == PMS_SRC_PRI);
		sec_flag_nxt = (act_nxt == PMS_SRC_SEC);
	end

	always_comb begin
		mode_nxt = mode_r;
		// Bits sampled as they stand when the instruction executes
		if (sleep_exec_i) begin
			if (deep_sleep_enable_bit_r) begin
				mode_nxt = PMS_DEEP;
			end else if (idle_r) begin
				mode_nxt = PMS_IDLE;
			end else begin
				mode_nxt = PMS_SLEEP;
			end
		end else if (wake_i) begin
			mode_nxt = PMS_RUN;
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				PMS_OSC_CTRL_ADDR: begin
					rdata_nxt[PMS_IDLE_BIT] = idle_r;
					rdata_nxt[PMS_PRI_FLAG_BIT] = pri_flag_r;
					rdata_nxt[PMS_SCS_LSB +: 2] = sel_r;
				end
				PMS_OSC_CTRL2_ADDR: rdata_nxt[PMS_SEC_FLAG_BIT] = sec_flag_r;
				PMS_DEEP_CTRL_ADDR: rdata_nxt[PMS_DEEP_SLEEP_ENABLE_BIT_BIT] = deep_sleep_enable_bit_r;
				PMS_MODE_STAT_ADDR: rdata_nxt[1:0] = mode_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_r <= pms_src_e'(PMS_SCS_RST);
			act_r <= pms_src_e'(PMS_SCS_RST);
			tgt_r <= pms_src_e'(PMS_SCS_RST);
			idle_r <= PMS_IDLE_RST;
			deep_sleep_enable_bit_r <= PMS_DEEP_SLEEP_ENABLE_BIT_RST;
			mode_r <= PMS_RUN;
			pri_flag_r <= 1'b1;
			sec_flag_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			sel_r <= sel_nxt;
			act_r <= act_nxt;
			tgt_r <= tgt_nxt;
			idle_r <= idle_nxt;
			deep_sleep_enable_bit_r <= deep_sleep_enable_bit_nxt;
			mode_r <= mode_nxt;
			pri_flag_r <= pri_flag_nxt;
			sec_flag_r <= sec_flag_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign clk_src_o = act_r;
	assign switching_o = sw.busy;
	assign pwr_mode_o = mode_r;
	assign cpu_clk_en_o = (mode_r == PMS_RUN);
	assign periph_clk_en_o = (mode_r == PMS_RUN) || (mode_r == PMS_IDLE);

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_sleep_deep;
		sleep_exec_i && deep_sleep_enable_bit_r;
	endsequence
	sequence s_sleep_idle;
		sleep_exec_i && !deep_sleep_enable_bit_r && idle_r;
	endsequence

	chk_flags_onehot: assert property (!(pri_flag_r && sec_flag_r))
		else $error("Both source flags set");
	chk_rc_flags: assert property (act_r == PMS_SRC_RC |-> !pri_flag_r && !sec_flag_r)
		else $error("Flag set while internal RC clocks device");
	chk_pri_flag: assert property (pri_flag_r == (act_r == PMS_SRC_PRI))
		else $error("Primary flag does not follow active source");
	chk_sec_flag: assert property (sec_flag_r == (act_r == PMS_SRC_SEC))
		else $error("Secondary flag does not follow active source");
	chk_flags_hold: assert property (!sw.done |=> $stable(pri_flag_r) && $stable(sec_flag_r))
		else $error("Source flags moved before transition completed");
	chk_deep_entry: assert property (s_sleep_deep |=> mode_r == PMS_DEEP)
		else $error("Deep Sleep not entered");
	chk_idle_entry: assert property (s_sleep_idle |=> mode_r == PMS_IDLE)
		else $error("Idle not entered");
	chk_sleep_entry: assert property (sleep_exec_i && !deep_sleep_enable_bit_r && !idle_r
		|=> mode_r == PMS_SLEEP)
		else $error("Sleep not entered");
	chk_resleep_mode: assert property ((mode_r != PMS_RUN) and s_sleep_idle
		|=> mode_r == PMS_IDLE)
		else $error("Later sleep did not take new mode");
	chk_switch_len: assert property (sw.start |=> sw.busy [*5])
		else $error("Transition shorter than five source edges");
endmodule

// file: include/pms_pkg.sv
// Package: constants and types for the power mode and clock switch block
package pms_pkg;
	// Register indices on the plain register port
	localparam logic [1:0] PMS_OSC_CTRL_ADDR = 2'h0;
	localparam logic [1:0] PMS_OSC_CTRL2_ADDR = 2'h1;
	localparam logic [1:0] PMS_DEEP_CTRL_ADDR = 2'h2;
	localparam logic [1:0] PMS_MODE_STAT_ADDR = 2'h3;
	// Field positions
	localparam int PMS_SCS_LSB = 0;
	localparam int PMS_PRI_FLAG_BIT = 3;
	localparam int PMS_IDLE_BIT = 7;
	localparam int PMS_SEC_FLAG_BIT = 6;
	localparam int PMS_DEEP_SLEEP_ENABLE_BIT_BIT = 0;
	// Reset values
	localparam logic [1:0] PMS_SCS_RST = 2'h0;
	localparam logic PMS_IDLE_RST = 1'b0;
	localparam logic PMS_DEEP_SLEEP_ENABLE_BIT_RST = 1'b0;
	// Transition length in source edges
	localparam logic [1:0] PMS_OLD_EDGES = 2'h2;
	localparam logic [1:0] PMS_NEW_EDGES = 2'h3;

	typedef enum logic [1:0] {
		PMS_SRC_PRI = 2'b00,
		PMS_SRC_SEC = 2'b01,
		PMS_SRC_BAD = 2'b10,
		PMS_SRC_RC = 2'b11
	} pms_src_e;

	typedef enum logic [1:0] {
		PMS_RUN = 2'b00,
		PMS_IDLE = 2'b01,
		PMS_SLEEP = 2'b11,
		PMS_DEEP = 2'b10
	} pms_mode_e;

	typedef enum logic [1:0] {
		PMS_TMR_IDLE = 2'b00,
		PMS_TMR_OLD = 2'b01,
		PMS_TMR_NEW = 2'b11
	} pms_tmr_e;

	function automatic logic pms_edge(input logic [2:0] ticks, input pms_src_e src);
		logic r;
		r = 1'b0;
		case (src)
			PMS_SRC_PRI: r = ticks[0];
			PMS_SRC_SEC: r = ticks[1];
			default: r = ticks[2];
		endcase
		return r;
	endfunction
endpackage

// file: include/pms_sw_if.sv
// Interface: handshake between mode controller and transition timer
`timescale 1ns/100ps
interface pms_sw_if;
	import pms_pkg::*;
	logic start;
	pms_src_e old_src;
	pms_src_e new_src;
	logic [2:0] ticks;
	logic busy;
	logic done;
	modport ctl (output start, output old_src, output new_src, output ticks,
		input busy, input done);
	modport tmr (input start, input old_src, input new_src, input ticks,
		output busy, output done);
endinterface

// file: rtl/pms_switch_timer.sv
// Clock transition timer: counts old-source then new-source edges
`timescale 1ns/100ps
module pms_switch_timer
	import pms_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	pms_sw_if.tmr sw
);
	pms_tmr_e state_r, state_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	pms_src_e old_r, old_nxt, new_r, new_nxt;
	// Completion is flagged in the last counting cycle so the source moves with idle
	logic finish;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		old_nxt = old_r;
		new_nxt = new_r;
		finish = 1'b0;
		case (state_r)
			PMS_TMR_IDLE: begin
				if (sw.start) begin
					state_nxt = PMS_TMR_OLD;
					cnt_nxt = 2'h0;
					old_nxt = sw.old_src;
					new_nxt = sw.new_src;
				end
			end
			PMS_TMR_OLD: begin
				// Two edges of the outgoing source
				if (pms_edge(sw.ticks, old_r)) begin
					if (cnt_r == PMS_OLD_EDGES - 2'h1) begin
						state_nxt = PMS_TMR_NEW;
						cnt_nxt = 2'h0;
					end else begin
						cnt_nxt = cnt_r + 2'h1;
					end
				end
			end
			PMS_TMR_NEW: begin
				// Three edges of the incoming source, within three to four
				if (pms_edge(sw.ticks, new_r)) begin
					if (cnt_r == PMS_NEW_EDGES - 2'h1) begin
						state_nxt = PMS_TMR_IDLE;
						finish = 1'b1;
					end else begin
						cnt_nxt = cnt_r + 2'h1;
					end
				end
			end
			default: state_nxt = PMS_TMR_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= PMS_TMR_IDLE;
			cnt_r <= 2'h0;
			old_r <= PMS_SRC_PRI;
			new_r <= PMS_SRC_PRI;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			old_r <= old_nxt;
			new_r <= new_nxt;
		end
	end

	assign sw.busy = (state_r != PMS_TMR_IDLE);
	assign sw.done = finish;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_new_last;
		state_r == PMS_TMR_NEW && cnt_r == PMS_NEW_EDGES - 2'h1 && pms_edge(sw.ticks, new_r);
	endsequence

	chk_start_busy: assert property (sw.start && !sw.busy |=> sw.busy)
		else $error("Timer did not start");
	chk_done_cause: assert property (s_new_last |-> sw.done ##1 !sw.busy)
		else $error("Done not raised after third new edge");
	chk_done_pulse: assert property (sw.done |-> state_r == PMS_TMR_NEW
		&& pms_edge(sw.ticks, new_r))
		else $error("Done without new-source edge");
	chk_old_phase: assert property (state_r == PMS_TMR_OLD && cnt_r == 2'h1
		&& pms_edge(sw.ticks, old_r) |=> state_r == PMS_TMR_NEW)
		else $error("Old phase not two edges");
endmodule

// file: test/pms_osc_model.sv
// Oscillator model: one-cycle tick pulses for each clock source
`timescale 1ns/100ps
module pms_osc_model (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic slow_i,
	output logic pri_tick_o,
	output logic sec_tick_o,
	output logic rc_tick_o
);
	logic [3:0] cnt_r [3];
	logic [3:0] per [3];
	logic [2:0] tick_r;

	// Slow mode stretches every source to test long transitions
	always_comb begin
		per[0] = slow_i ? 4'h9 : 4'h4;
		per[1] = slow_i ? 4'hD : 4'h5;
		per[2] = slow_i ? 4'h7 : 4'h3;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		for (int i = 0; i < 3; i++) begin
			if (!arst_n_i) begin
				cnt_r[i] <= 4'h0;
				tick_r[i] <= 1'b0;
			end else begin
				cnt_r[i] <= (cnt_r[i] >= per[i] - 4'h1) ? 4'h0 : cnt_r[i] + 4'h1;
				tick_r[i] <= (cnt_r[i] == 4'h0);
			end
		end
	end

	assign pri_tick_o = tick_r[0];
	assign sec_tick_o = tick_r[1];
	assign rc_tick_o = tick_r[2];
endmodule

// file: test/tb.sv
// Testbench: register access, clock switching and sleep modes
`timescale 1ns/100ps
module tb;
	import pms_pkg::*;
	logic clk, rst_n, wr, rd, slp, wake, slow, swg, cpu_en, per_en;
	logic [1:0] addr, src, mode;
	logic [7:0] wd, rdata;
	wire [2:0] tk;
	int n_fail = 0, tests_run = 0, cyc = 0;

	pms_top dut (.sys_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sleep_exec_i(slp),
		.wake_i(wake), .pri_tick_i(tk[0]), .sec_tick_i(tk[1]), .rc_tick_i(tk[2]),
		.clk_src_o(src), .switching_o(swg), .pwr_mode_o(mode), .cpu_clk_en_o(cpu_en),
		.periph_clk_en_o(per_en));
	pms_osc_model osc (.sys_clk_i(clk), .arst_n_i(rst_n), .slow_i(slow),
		.pri_tick_o(tk[0]), .sec_tick_o(tk[1]), .rc_tick_o(tk[2]));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrt(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1; addr <= a; wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rdc(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1; addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("read data", e, rdata);
	endtask

	function automatic int idx(input logic [1:0] s);
		return (s == 2'b11) ? 2 : int'(s[0]);
	endfunction

	task automatic swto(input logic [1:0] s, input logic [1:0] o);
		int no, nn, k;
		logic seen;
		no = 0; nn = 0; seen = 1'b0;
		wrt(PMS_OSC_CTRL_ADDR, {6'h00, s});
		for (k = 0; k < 400; k++) begin
			@(negedge clk);
			if (swg === 1'b1) begin
				seen = 1'b1;
				chk("source during switch", {6'h00, o}, {6'h00, src});
				if (tk[idx(o)] && no < 2) no++;
				else if (no >= 2 && tk[idx(s)]) nn++;
			end else if (seen) break;
		end
		chk("old ticks", 8'h02, no[7:0]);
		chk("new ticks in range", 8'h01, {7'h00, nn >= 3 && nn <= 4});
		chk("source after switch", {6'h00, s}, {6'h00, src});
		rdc(PMS_OSC_CTRL_ADDR, {4'h0, s == 2'b00, 1'b0, s});
		rdc(PMS_OSC_CTRL2_ADDR, {1'b0, s == 2'b01, 6'h00});
	endtask

	task automatic sleep_chk(input logic ds, input logic il, input pms_mode_e m);
		wrt(PMS_DEEP_CTRL_ADDR, {7'h00, ds});
		wrt(PMS_OSC_CTRL_ADDR, {il, 7'h00});
		@(posedge clk);
		slp <= 1'b1;
		@(posedge clk);
		slp <= 1'b0;
		@(negedge clk);
		chk("mode", {6'h00, m}, {6'h00, mode});
		chk("enables", {6'h00, m == PMS_IDLE, 1'b0}, {6'h00, per_en, cpu_en});
		rdc(PMS_MODE_STAT_ADDR, {6'h00, m});
	endtask

	initial begin
		rst_n = 1'b0; wr = 1'b0; rd = 1'b0; slp = 1'b0; wake = 1'b0; slow = 1'b0;
		addr = 2'h0; wd = 8'h00;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rdc(PMS_OSC_CTRL_ADDR, 8'h08);
		rdc(PMS_OSC_CTRL2_ADDR, 8'h00);
		swto(2'b01, 2'b00);
		slow <= 1'b1;
		swto(2'b11, 2'b01);
		slow <= 1'b0;
		swto(2'b00, 2'b11);
		// Reserved select code must leave the source alone
		wrt(PMS_OSC_CTRL_ADDR, 8'h02);
		repeat (20) @(posedge clk);
		rdc(PMS_OSC_CTRL_ADDR, 8'h08);
		swto(2'b11, 2'b00);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("source after reset", 8'h00, {6'h00, src});
		rdc(PMS_OSC_CTRL_ADDR, 8'h08);
		sleep_chk(1'b0, 1'b0, PMS_SLEEP);
		sleep_chk(1'b0, 1'b1, PMS_IDLE);
		sleep_chk(1'b1, 1'b0, PMS_DEEP);
		sleep_chk(1'b1, 1'b1, PMS_DEEP);
		sleep_chk(1'b0, 1'b0, PMS_SLEEP);
		// Write beside the sleep edge must not be seen by that sleep
		@(posedge clk);
		slp <= 1'b1; wr <= 1'b1; addr <= PMS_DEEP_CTRL_ADDR; wd <= 8'h01;
		@(posedge clk);
		slp <= 1'b0; wr <= 1'b0;
		@(negedge clk);
		chk("mode same cycle", {6'h00, PMS_SLEEP}, {6'h00, mode});
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		@(negedge clk);
		chk("mode after wake", {4'h0, 2'b11, PMS_RUN}, {4'h0, per_en, cpu_en, mode});
		sleep_chk(1'b1, 1'b0, PMS_DEEP);
		wrap_up();
	end
endmodule
